//--- design/rx_payload_cfg.svh
// constants for the receive channel payload control block
`ifndef RX_PAYLOAD_CFG_SVH
`define RX_PAYLOAD_CFG_SVH

// indirect address windows, channel 1 at the base
`define CHAN_CTL_BASE     7'h01
`define TRUNK_CODE_BASE   7'h21
`define SIG_TRUNK_BASE    7'h41
`define NUM_CHANNELS      24
`define GLOBAL_CTL_ADDR   7'h60
`define STATUS_ADDR       7'h61

// channel control field positions
`define CTL_REPLACE_MSB   7
`define CTL_REPLACE_LSB   5
`define CTL_SIGN_INV      4
`define CTL_ODD_INV       3
`define CTL_EVEN_INV      2
`define CTL_LSB_GAP       1
`define CTL_CHAN_GAP      0

// global control field positions
`define GCTL_REPLACE_MSB  2
`define GCTL_REPLACE_LSB  0
`define GCTL_CLK_CTL_EN   3
`define GCTL_CLK_MASTER   4

// reset values and masks
`define CTL_RESET         8'h00
`define TRUNK_RESET       8'h00
`define SIG_TRUNK_RESET   8'h00
`define GCTL_RESET        8'h00
`define SIG_TRUNK_WMASK   8'h5F
`define GCTL_WMASK        8'h1F

// inversion masks, bit 1 of the channel is the msb
`define INV_SIGN_MASK     8'h80
`define INV_ODD_MASK      8'h2A
`define INV_EVEN_MASK     8'h55
`define GAP_ALL_MASK      8'hFF
`define GAP_LSB_MASK      8'h01

// digital milliwatt sequences, first byte in the top lane
`define MW_ALAW_SEQ       64'h34_21_21_34_B4_A1_A1_B4
`define MW_ULAW_SEQ       64'h1E_0B_0B_1E_9E_8B_8B_9E

`endif

//--- design/rx_payload_pkg.sv
// types shared by the receive channel payload control block
package rx_payload_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] reg_addr_t;
    typedef logic [4:0] chan_idx_t;

    // replacement selection codes; other codes are reserved
    typedef enum logic [2:0] {
        REPL_NONE  = 3'h0,
        REPL_TRUNK = 3'h1,
        REPL_ALAW  = 3'h2,
        REPL_ULAW  = 3'h3
    } replace_e;

endpackage

//--- design/rx_payload_ctl.sv
// receive channel payload control: per-channel replacement, inversion and gapping
`timescale 1ns/1ps
`include "rx_payload_cfg.svh"

// How it works
// - addresses 01H to 18H hold channel control registers for channels 1 to 24
// - addresses 21H to 38H hold each channel's data trunk code
// - addresses 41H to 58H hold each channel's signaling trunk code
// - per-channel replacement applies only while global selection is zero
// - code 000 passes data, 001 substitutes the channel's data trunk code
// - code 010 sends A-law milliwatt, 011 sends mu-law milliwatt
// - no selector means no inversion; even selector inverts bits 2,4,6,8
// - odd selector alone inverts bits 3,5,7, msb kept
// - odd and even without sign invert bits 2 through 8
// - all three selectors invert all eight bits
// - sign adds bit 1 to whatever the odd and even selectors invert
// - in clock master mode with clock control, gap bit 8 or whole channel
// - each data trunk register holds an eight bit substitution code
module rx_payload_ctl #(
    parameter int CHANNELS = `NUM_CHANNELS
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // register port
    input  wire rx_payload_pkg::reg_addr_t reg_addr,
    input  wire rx_payload_pkg::byte_t reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output rx_payload_pkg::byte_t      reg_rdata,
    // channel bytes from the receive framer
    input  wire logic                  in_valid,
    input  wire rx_payload_pkg::chan_idx_t in_chan,
    input  wire rx_payload_pkg::byte_t in_byte,
    // channel bytes toward the system side
    output logic                       out_valid,
    output rx_payload_pkg::chan_idx_t  out_chan,
    output rx_payload_pkg::byte_t      out_byte,
    output rx_payload_pkg::byte_t      out_clk_gap
);

    typedef struct packed {
        logic hit;
        rx_payload_pkg::chan_idx_t idx;
    } slot_s;

    // channel control byte split into its fields
    typedef struct packed {
        logic [2:0] chan_replace_sel;
        logic       sign_bit_invert;
        logic       odd_bits_invert;
        logic       even_bits_invert;
        logic       lsb_clock_gap;
        logic       chan_clock_gap;
    } chan_ctl_s;

    // global control byte split into its fields
    typedef struct packed {
        logic [2:0] global_replace_sel;
        logic       per_channel_clock_ctl_en;
        logic       clock_master;
    } global_ctl_s;

    function automatic chan_ctl_s unpack_ctl(input rx_payload_pkg::byte_t b);
        chan_ctl_s c;
        c.chan_replace_sel = b[`CTL_REPLACE_MSB:`CTL_REPLACE_LSB];
        c.sign_bit_invert  = b[`CTL_SIGN_INV];
        c.odd_bits_invert  = b[`CTL_ODD_INV];
        c.even_bits_invert = b[`CTL_EVEN_INV];
        c.lsb_clock_gap    = b[`CTL_LSB_GAP];
        c.chan_clock_gap   = b[`CTL_CHAN_GAP];
        return c;
    endfunction

    function automatic global_ctl_s unpack_global(input rx_payload_pkg::byte_t b);
        global_ctl_s g;
        g.global_replace_sel       = b[`GCTL_REPLACE_MSB:`GCTL_REPLACE_LSB];
        g.per_channel_clock_ctl_en = b[`GCTL_CLK_CTL_EN];
        g.clock_master             = b[`GCTL_CLK_MASTER];
        return g;
    endfunction

    // maps an address onto a channel slot of a 24-entry window
    function automatic slot_s win_decode(input rx_payload_pkg::reg_addr_t a,
                                         input rx_payload_pkg::reg_addr_t base);
        logic [6:0] off;
        slot_s      s;
        off   = a - base;
        s.hit = (a >= base) && (off < 7'(CHANNELS));
        s.idx = off[4:0];
        return s;
    endfunction

    // picks one byte of an eight byte milliwatt sequence
    function automatic rx_payload_pkg::byte_t seq_pick(input logic [63:0] seq,
                                                       input logic [2:0]  ph);
        return seq[63 - 8 * ph -: 8];
    endfunction

    rx_payload_pkg::byte_t chan_ctl_ff  [CHANNELS];
    rx_payload_pkg::byte_t trunk_ff     [CHANNELS];
    rx_payload_pkg::byte_t sig_trunk_ff [CHANNELS];
    rx_payload_pkg::byte_t global_ctl_ff;
    rx_payload_pkg::byte_t rdata_ff;
    logic [2:0]            mw_phase_ff;
    rx_payload_pkg::chan_idx_t last_chan_ff;
    logic                  out_valid_ff;
    rx_payload_pkg::chan_idx_t out_chan_ff;
    rx_payload_pkg::byte_t out_byte_ff;
    rx_payload_pkg::byte_t out_gap_ff;

    slot_s wr_ctl;
    slot_s wr_trk;
    slot_s wr_sig;

    assign wr_ctl = win_decode(reg_addr, `CHAN_CTL_BASE);
    assign wr_trk = win_decode(reg_addr, `TRUNK_CODE_BASE);
    assign wr_sig = win_decode(reg_addr, `SIG_TRUNK_BASE);

    // one register slice per channel; each slice only sees its own write hit
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        logic ctl_we;
        logic trk_we;
        logic sig_we;

        assign ctl_we = reg_wr && wr_ctl.hit && (wr_ctl.idx == 5'(ch));
        assign trk_we = reg_wr && wr_trk.hit && (wr_trk.idx == 5'(ch));
        assign sig_we = reg_wr && wr_sig.hit && (wr_sig.idx == 5'(ch));

        always_ff @(posedge clock)
        begin
            if (srst)
                chan_ctl_ff[ch] <= `CTL_RESET;
            else if (ctl_we)
                chan_ctl_ff[ch] <= reg_wdata;
        end

        always_ff @(posedge clock)
        begin
            if (srst)
                trunk_ff[ch] <= `TRUNK_RESET;
            else if (trk_we)
                trunk_ff[ch] <= reg_wdata;
        end

        always_ff @(posedge clock)
        begin
            if (srst)
                sig_trunk_ff[ch] <= `SIG_TRUNK_RESET;
            else if (sig_we)
                sig_trunk_ff[ch] <= reg_wdata & `SIG_TRUNK_WMASK;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            global_ctl_ff <= `GCTL_RESET;
        else if (reg_wr && reg_addr == `GLOBAL_CTL_ADDR)
            global_ctl_ff <= reg_wdata & `GCTL_WMASK;
    end

    // read data stands only in the cycle after the strobe
    rx_payload_pkg::byte_t nxt_rdata;

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (!reg_rd)
            nxt_rdata = 8'h00;
        else if (wr_ctl.hit)
            nxt_rdata = chan_ctl_ff[wr_ctl.idx];
        else if (wr_trk.hit)
            nxt_rdata = trunk_ff[wr_trk.idx];
        else if (wr_sig.hit)
            nxt_rdata = sig_trunk_ff[wr_sig.idx];
        else if (reg_addr == `GLOBAL_CTL_ADDR)
            nxt_rdata = global_ctl_ff;
        else if (reg_addr == `STATUS_ADDR)
            nxt_rdata = {mw_phase_ff, last_chan_ff};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata = rdata_ff;

    // milliwatt phase advances once per frame, after the last channel
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mw_phase_ff  <= 3'h0;
            last_chan_ff <= 5'h00;
        end
        else if (in_valid)
        begin
            last_chan_ff <= in_chan;
            if (in_chan == 5'(CHANNELS - 1))
                mw_phase_ff <= mw_phase_ff + 3'h1;
        end
    end

    // payload path, combinational part
    logic                  chan_ok;
    rx_payload_pkg::byte_t cur_ctl;
    rx_payload_pkg::byte_t cur_trunk;
    logic [2:0]            g_sel;
    logic [2:0]            eff_sel;
    rx_payload_pkg::byte_t replaced;
    rx_payload_pkg::byte_t inv_mask;
    rx_payload_pkg::byte_t nxt_out_byte;
    rx_payload_pkg::byte_t nxt_gap;
    chan_ctl_s             cur_f;
    global_ctl_s           glob_f;

    assign chan_ok   = in_chan < 5'(CHANNELS);
    assign cur_ctl   = chan_ok ? chan_ctl_ff[in_chan] : 8'h00;
    assign cur_trunk = chan_ok ? trunk_ff[in_chan] : 8'h00;
    assign g_sel     = global_ctl_ff[`GCTL_REPLACE_MSB:`GCTL_REPLACE_LSB];
    assign cur_f     = unpack_ctl(cur_ctl);
    assign glob_f    = unpack_global(global_ctl_ff);

    always_comb
    begin
        // global selection overrides the channel's own choice
        eff_sel = (g_sel == 3'h0) ? cur_f.chan_replace_sel : glob_f.global_replace_sel;
        case (eff_sel)
            rx_payload_pkg::REPL_TRUNK: replaced = cur_trunk;
            rx_payload_pkg::REPL_ALAW:  replaced = seq_pick(`MW_ALAW_SEQ, mw_phase_ff);
            rx_payload_pkg::REPL_ULAW:  replaced = seq_pick(`MW_ULAW_SEQ, mw_phase_ff);
            default:                    replaced = in_byte;
        endcase
    end

    always_comb
    begin
        // selectors combine; sign covers bit 1 only, so every mix is an or of masks
        inv_mask = 8'h00;
        if (cur_f.sign_bit_invert)
            inv_mask = inv_mask | `INV_SIGN_MASK;
        if (cur_f.odd_bits_invert)
            inv_mask = inv_mask | `INV_ODD_MASK;
        if (cur_f.even_bits_invert)
            inv_mask = inv_mask | `INV_EVEN_MASK;
        nxt_out_byte = replaced ^ inv_mask;
    end

    always_comb
    begin
        nxt_gap = 8'h00;
        if (glob_f.clock_master && glob_f.per_channel_clock_ctl_en)
        begin
            if (cur_f.chan_clock_gap)
                nxt_gap = `GAP_ALL_MASK;
            else if (cur_f.lsb_clock_gap)
                nxt_gap = `GAP_LSB_MASK;
        end
    end

    // one cycle of latency, data outputs from flip-flops
    always_ff @(posedge clock)
    begin
        if (srst)
            out_valid_ff <= 1'b0;
        else
            out_valid_ff <= in_valid;
    end

    // data hold between bytes so a slow reader still sees the last one
    always_ff @(posedge clock)
    begin
        if (srst)
            out_chan_ff <= 5'h00;
        else if (in_valid)
            out_chan_ff <= in_chan;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            out_byte_ff <= 8'h00;
        else if (in_valid)
            out_byte_ff <= nxt_out_byte;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            out_gap_ff <= 8'h00;
        else if (in_valid)
            out_gap_ff <= nxt_gap;
    end

    assign out_valid   = out_valid_ff;
    assign out_chan    = out_chan_ff;
    assign out_byte    = out_byte_ff;
    assign out_clk_gap = out_gap_ff;

endmodule // rx_payload_ctl

//--- test/rx_payload_monitor.sv
// port checker for the receive payload control block
`timescale 1ns/1ps
module rx_payload_monitor #(parameter int CHANNELS = 24) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // register port
    input wire rx_payload_pkg::reg_addr_t reg_addr,
    input wire rx_payload_pkg::byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rx_payload_pkg::byte_t reg_rdata,
    // stream
    input wire logic in_valid,
    input wire rx_payload_pkg::chan_idx_t in_chan,
    input wire rx_payload_pkg::byte_t in_byte,
    input wire logic out_valid,
    input wire rx_payload_pkg::chan_idx_t out_chan,
    input wire rx_payload_pkg::byte_t out_byte,
    input wire rx_payload_pkg::byte_t out_clk_gap
);
    // shadow of the global byte; override and gapping hinge on it
    rx_payload_pkg::byte_t gctl_ff;
    always_ff @(posedge clock)
        if (srst)
            gctl_ff <= 8'h00;
        else if (reg_wr && reg_addr == 7'h60)
            gctl_ff <= reg_wdata;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_valid_follows: assert property (in_valid |=> out_valid)
        else $error("out_valid missing");
    a_no_extra: assert property (!in_valid |=> !out_valid)
        else $error("out_valid spurious");
    a_chan_carried: assert property (in_valid |=> out_chan == $past(in_chan))
        else $error("out_chan wrong");
    a_out_holds: assert property (!in_valid |=> $stable(out_byte) && $stable(out_chan))
        else $error("output moved while idle");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("reg_rdata not cleared");
    a_hole_reads: assert property (reg_rd && reg_addr inside {[7'h19:7'h20]} |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_bad_chan: assert property (in_valid && in_chan >= CHANNELS && gctl_ff[2:0] == 3'h0
        |=> out_byte == $past(in_byte))
        else $error("out of range channel altered");
    a_gap_gated: assert property (in_valid && gctl_ff[4:3] != 2'b11 |=> out_clk_gap == 8'h00)
        else $error("gap outside clock control");
endmodule // rx_payload_monitor
bind rx_payload_ctl rx_payload_monitor #(.CHANNELS(CHANNELS)) monitor (.clock, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_chan, .in_byte, .out_valid, .out_chan,
    .out_byte, .out_clk_gap);

//--- test/rx_framer_model.sv
// behavioural receive framer feeding channel bytes
`timescale 1ns/1ps
module rx_framer_model (
    // clock, reset, bench command
    input wire logic clock,
    input wire logic srst,
    input wire logic send,
    input wire rx_payload_pkg::chan_idx_t chan,
    input wire rx_payload_pkg::byte_t data,
    // toward the block
    output logic in_valid = 1'b0,
    output rx_payload_pkg::chan_idx_t in_chan = '0,
    output rx_payload_pkg::byte_t in_byte = '0
);
    // idle byte toggles so stale data never passes for fresh
    always @(posedge clock)
    begin
        in_valid <= send && !srst;
        in_chan <= send ? chan : in_chan;
        in_byte <= send ? data : ~in_byte;
    end
endmodule // rx_framer_model

//--- test/receive_channel_payload_control_bench.sv
// self-checking bench for the receive payload control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module receive_channel_payload_control_bench;
    logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, send = 0, in_valid, out_valid;
    rx_payload_pkg::reg_addr_t reg_addr = '0;
    rx_payload_pkg::byte_t reg_wdata = '0, data = '0, reg_rdata, in_byte, out_byte, out_clk_gap;
    rx_payload_pkg::chan_idx_t chan = '0, in_chan, out_chan;
    int failures = 0, tests_run = 0;
    initial forever #12.5 clock = ~clock;
    rx_framer_model framer (.clock, .srst, .send, .chan, .data, .in_valid, .in_chan, .in_byte);
    rx_payload_ctl uut (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .in_valid, .in_chan, .in_byte, .out_valid, .out_chan, .out_byte, .out_clk_gap);
    task automatic wr(input rx_payload_pkg::reg_addr_t a, input rx_payload_pkg::byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input rx_payload_pkg::reg_addr_t a, input rx_payload_pkg::byte_t e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata)
    endtask
    // framer adds one cycle, the block one more
    task automatic xfer(input rx_payload_pkg::chan_idx_t c, input rx_payload_pkg::byte_t b, e, g);
        @(posedge clock);
        chan <= c;
        data <= b;
        send <= 1'b1;
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        #1 `CHK("out_valid", 1'b1, out_valid)
        `CHK("out_chan", c, out_chan)
        `CHK("out_byte", e, out_byte)
        `CHK("out_clk_gap", g, out_clk_gap)
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        rd(7'h01, 8'h00);
        rd(7'h21, 8'h00);
        wr(7'h18, 8'h5A);
        rd(7'h18, 8'h5A);
        rd(7'h19, 8'h00);
        wr(7'h38, 8'h81);
        rd(7'h38, 8'h81);
        wr(7'h58, 8'hFF);
        rd(7'h58, 8'h5F);
        for (int i = 0; i < 8; i++)
        begin
            wr(7'h01, 8'(i << 2));
            xfer(5'd0, 8'hA5, 8'hA5 ^ ((i[2] ? 8'h80 : 8'h00) | (i[1] ? 8'h2A : 8'h00)
                | (i[0] ? 8'h55 : 8'h00)), 8'h00);
        end
        wr(7'h22, 8'h3C);
        wr(7'h02, 8'h30);
        xfer(5'd1, 8'h5A, 8'hBC, 8'h00);
        wr(7'h02, 8'hA0);
        xfer(5'd1, 8'h5A, 8'h5A, 8'h00);
        xfer(5'd24, 8'h77, 8'h77, 8'h00);
        wr(7'h60, 8'h01);
        xfer(5'd1, 8'h5A, 8'h3C, 8'h00);
        wr(7'h60, 8'h00);
        wr(7'h18, 8'h40);
        xfer(5'd23, 8'h00, 8'h34, 8'h00);
        xfer(5'd23, 8'h00, 8'h21, 8'h00);
        wr(7'h18, 8'h60);
        xfer(5'd23, 8'h00, 8'h0B, 8'h00);
        rd(7'h61, 8'h77);
        wr(7'h03, 8'h02);
        xfer(5'd2, 8'h11, 8'h11, 8'h00);
        wr(7'h60, 8'h18);
        rd(7'h60, 8'h18);
        xfer(5'd2, 8'h11, 8'h11, 8'h01);
        wr(7'h04, 8'h03);
        xfer(5'd3, 8'h22, 8'h22, 8'hFF);
        tally_and_finish();
    end
endmodule // receive_channel_payload_control_bench
